// File: frame_bridge_defs.svh
`ifndef FRAME_BRIDGE_DEFS_SVH
`define FRAME_BRIDGE_DEFS_SVH

// cpu address is 22 bits, a word address on frames 0 to 2 and a byte address on the byte bridge; bits 13:12 select the frame
`define ADDR_W 22
`define FRAME_LSB 12
`define FRAME_W 2
`define FRAME0_SEL 2'h0
`define FRAME1_SEL 2'h1
`define FRAME2_SEL 2'h2
`define FRAME_BYTE_SEL 2'h3
// word-addressed local offset width inside frames 0 to 2; the byte bridge uses BYTE_AW byte-offset bits
`define LOCAL_W 12
// can control and status block on frame 1: word offsets below this bound
`define CAN_CTRL_LIMIT 12'h040
// per-frame memory address width, in 32-bit rows
`define MEM_AW 8
// byte bridge: 32-bit registers at steps of 4, 16-bit words at steps of 2
`define BYTE_REG_STEP 4
`define BYTE_HALF_STEP 2
`define UPPER_HALF_OFS 2
`define BYTE_AW 10

`endif

// File: frame_bridge_pkg.sv
package frame_bridge_pkg;
    typedef enum logic [1:0] {
        width_16 = 2'h0,
        width_32 = 2'h1,
        width_8 = 2'h2
    } access_width_t;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_access = 2'b01,
        st_done = 2'b11
    } bridge_state_t;
endpackage

// File: frame_word_mem.sv
`timescale 1ns/1ns
`default_nettype none
// dual-half word memory: 8-bit lanes written under lane enables, registered read
module frame_word_mem #(
    parameter int AW = 8
) (
    input wire logic clk_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic wr_in,
    input wire logic [3:0] lane_in,
    input wire logic [31:0] wdata_in,
    output logic [31:0] rdata_out
);
    logic [7:0] bytes_r [0:(1<<AW)-1][0:3];

    always_ff @(posedge clk_in) begin
        for (int i = 0; i < 4; i++) begin
            if (wr_in && lane_in[i]) begin
                bytes_r[addr_in][i] <= wdata_in[8*i +: 8];
            end
        end
        rdata_out <= {bytes_r[addr_in][3], bytes_r[addr_in][2], bytes_r[addr_in][1], bytes_r[addr_in][0]};
    end
endmodule // frame_word_mem
`default_nettype wire

// File: peripheral_frame_access_bridge.sv
`timescale 1ns/1ns
`default_nettype none
`include "frame_bridge_defs.svh"
module peripheral_frame_access_bridge (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic req_in,
    input wire logic wr_in,
    input wire logic [1:0] width_in,
    input wire logic [`ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    output logic ready_out,
    output logic [31:0] rdata_out,
    output logic err_out,
    output logic busy_out
);
    // request captured so the frame memories see a stable address
    frame_bridge_pkg::bridge_state_t state_r, state_nxt;
    logic wr_r;
    frame_bridge_pkg::access_width_t width_r;
    logic [`ADDR_W-1:0] addr_r;
    logic [31:0] wdata_r;
    logic [31:0] rdata_r;
    logic err_r;
    logic reject_r;

    wire logic [`FRAME_W-1:0] frame_sel = addr_r[`FRAME_LSB +: `FRAME_W];
    wire logic [`LOCAL_W-1:0] local_ofs = addr_r[`LOCAL_W-1:0];
    wire logic is_f0 = (frame_sel == `FRAME0_SEL);
    wire logic is_f1 = (frame_sel == `FRAME1_SEL);
    wire logic is_f2 = (frame_sel == `FRAME2_SEL);
    wire logic is_byte = (frame_sel == `FRAME_BYTE_SEL);
    wire logic w16 = (width_r == frame_bridge_pkg::width_16);
    wire logic w32 = (width_r == frame_bridge_pkg::width_32);
    wire logic w8 = (width_r == frame_bridge_pkg::width_8);
    wire logic can_ctrl = is_f1 && (local_ofs < `CAN_CTRL_LIMIT);

    // legality per frame
    wire logic f01_ok = (is_f0 || is_f1) && (w16 || w32) && !(can_ctrl && !w32);
    wire logic f2_ok = is_f2 && w16;
    // 32-bit on the bridge must be 4-aligned, 16-bit 2-aligned, byte anywhere
    wire logic byte_ok = is_byte && (w8 || (w16 && !addr_r[0]) || (w32 && addr_r[1:0] == 2'h0));
    wire logic legal = f01_ok || f2_ok || byte_ok;

    // word-addressed frames: odd word address of a 32-bit access is forced even
    function automatic logic [`MEM_AW-1:0] word_row(input logic [`LOCAL_W-1:0] ofs);
        word_row = ofs[`MEM_AW:1];
    endfunction

    // byte bridge: the address is a byte offset; row of 4 bytes plus lane
    wire logic [`BYTE_AW-1:0] byte_ofs = addr_r[`BYTE_AW-1:0];
    wire logic [`MEM_AW-1:0] byte_row = byte_ofs[`MEM_AW+1:2];
    wire logic [1:0] byte_lane = byte_ofs[1:0];

    // lane enables, one function used by frames 0 and 1 and the byte bridge
    function automatic logic [3:0] lanes(input logic bytemode, input logic [1:0] lane_sel,
                                         input frame_bridge_pkg::access_width_t w);
        if (w == frame_bridge_pkg::width_32) begin
            lanes = 4'hf;
        end else if (w == frame_bridge_pkg::width_16) begin
            lanes = lane_sel[1] ? 4'hc : 4'h3;
        end else begin
            lanes = bytemode ? (4'h1 << lane_sel) : 4'h0;
        end
    endfunction

    // word frames: upper half of a 32-bit row is the odd word address
    wire logic [1:0] word_lane = {local_ofs[0], 1'b0};
    // bridged 16-bit word at base+2 is the upper half of the register
    wire logic [1:0] half_lane = {byte_lane[1], 1'b0};

    wire logic [`MEM_AW-1:0] f0_row = word_row(local_ofs);
    wire logic [3:0] word_lanes = lanes(1'b0, word_lane, width_r);
    wire logic [3:0] b_lanes = w8 ? lanes(1'b1, byte_lane, width_r) : lanes(1'b0, half_lane, width_r);
    wire logic do_wr = (state_r == frame_bridge_pkg::st_access) && wr_r && legal;

    logic [31:0] f0_rd, f1_rd, f2_rd, fb_rd;

    frame_word_mem #(.AW(`MEM_AW)) f0_mem (
        .clk_in(clk_in),
        .addr_in(f0_row),
        .wr_in(do_wr && is_f0),
        .lane_in(word_lanes),
        .wdata_in(wdata_r),
        .rdata_out(f0_rd)
    );

    frame_word_mem #(.AW(`MEM_AW)) f1_mem (
        .clk_in(clk_in),
        .addr_in(f0_row),
        .wr_in(do_wr && is_f1),
        .lane_in(word_lanes),
        .wdata_in(wdata_r),
        .rdata_out(f1_rd)
    );

    // frame 2 is a plain 16-bit store; only the low lanes are ever used
    frame_word_mem #(.AW(`MEM_AW)) f2_mem (
        .clk_in(clk_in),
        .addr_in(local_ofs[`MEM_AW-1:0]),
        .wr_in(do_wr && is_f2),
        .lane_in(4'h3),
        .wdata_in({16'h0000, wdata_r[15:0]}),
        .rdata_out(f2_rd)
    );

    frame_word_mem #(.AW(`MEM_AW)) fb_mem (
        .clk_in(clk_in),
        .addr_in(byte_row),
        .wr_in(do_wr && is_byte),
        .lane_in(b_lanes),
        .wdata_in(wdata_r),
        .rdata_out(fb_rd)
    );

    // write data arrive right-aligned; steer them onto the selected lanes
    function automatic logic [31:0] steer_in(input logic [31:0] d, input logic [1:0] lane_sel,
                                             input frame_bridge_pkg::access_width_t w);
        if (w == frame_bridge_pkg::width_32) begin
            steer_in = d;
        end else if (w == frame_bridge_pkg::width_16) begin
            steer_in = {d[15:0], d[15:0]};
        end else begin
            steer_in = {4{d[7:0]}};
        end
    endfunction

    // read data: pick the lanes and right-align
    function automatic logic [31:0] align_out(input logic [31:0] d, input logic [1:0] lane_sel,
                                              input frame_bridge_pkg::access_width_t w);
        if (w == frame_bridge_pkg::width_32) begin
            align_out = d;
        end else if (w == frame_bridge_pkg::width_16) begin
            align_out = {16'h0000, lane_sel[1] ? d[31:16] : d[15:0]};
        end else begin
            align_out = {24'h000000, d[8*lane_sel +: 8]};
        end
    endfunction

    wire logic [1:0] rd_lane = is_byte ? (w8 ? byte_lane : half_lane) : word_lane;
    wire logic [31:0] sel_rd = is_f0 ? f0_rd : is_f1 ? f1_rd : is_f2 ? {16'h0000, f2_rd[15:0]} : fb_rd;
    wire logic [31:0] rd_aligned = is_f2 ? sel_rd : align_out(sel_rd, rd_lane, width_r);
    wire logic [31:0] wdata_steered = steer_in(wdata_in, 2'h0, frame_bridge_pkg::access_width_t'(width_in));

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            frame_bridge_pkg::st_idle: begin
                if (req_in) begin
                    state_nxt = frame_bridge_pkg::st_access;
                end
            end
            frame_bridge_pkg::st_access: begin
                state_nxt = frame_bridge_pkg::st_done;
            end
            default: begin
                state_nxt = frame_bridge_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= frame_bridge_pkg::st_idle;
            wr_r <= 1'b0;
            width_r <= frame_bridge_pkg::width_16;
            addr_r <= '0;
            wdata_r <= 32'h00000000;
        end else begin
            state_r <= state_nxt;
            if (state_r == frame_bridge_pkg::st_idle && req_in) begin
                wr_r <= wr_in;
                width_r <= frame_bridge_pkg::access_width_t'(width_in);
                addr_r <= addr_in;
                wdata_r <= wdata_steered;
            end
        end
    end

    // refused accesses write nothing and return zero with err
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reject_r <= 1'b0;
        end else if (state_r == frame_bridge_pkg::st_access) begin
            reject_r <= !legal;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_r <= 32'h00000000;
            err_r <= 1'b0;
        end else if (state_r == frame_bridge_pkg::st_done) begin
            rdata_r <= (reject_r || wr_r) ? 32'h00000000 : rd_aligned;
            err_r <= reject_r;
        end
    end

    assign ready_out = (state_r == frame_bridge_pkg::st_done);
    assign busy_out = (state_r != frame_bridge_pkg::st_idle);
    // data and error are valid with ready; taken from the done-cycle mux
    assign rdata_out = ready_out ? ((reject_r || wr_r) ? 32'h00000000 : rd_aligned) : rdata_r;
    assign err_out = ready_out ? reject_r : err_r;

    // request-side checks look two edges ahead, where the answer stands
    frame2_no32_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (req_in && !busy_out && addr_in[`FRAME_LSB +: `FRAME_W] == `FRAME2_SEL && width_in == 2'h1)
        |-> ##2 (ready_out && err_out))
        else $error("wide access to frame 2 accepted");
    can_ctrl_16_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (req_in && !busy_out && addr_in[`FRAME_LSB +: `FRAME_W] == `FRAME1_SEL
         && addr_in[`LOCAL_W-1:0] < `CAN_CTRL_LIMIT && width_in == 2'h0)
        |-> ##2 (ready_out && err_out))
        else $error("16-bit can control access accepted");
    frame1_other_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (req_in && !busy_out && addr_in[`FRAME_LSB +: `FRAME_W] == `FRAME1_SEL
         && addr_in[`LOCAL_W-1:0] >= `CAN_CTRL_LIMIT && width_in == 2'h0)
        |-> ##2 (ready_out && !err_out))
        else $error("frame 1 register refused 16-bit access");
    frame0_both_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (req_in && !busy_out && addr_in[`FRAME_LSB +: `FRAME_W] == `FRAME0_SEL && width_in[1] == 1'b0)
        |-> ##2 (ready_out && !err_out))
        else $error("frame 0 access refused");
    frame2_narrow_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (ready_out && is_f2)
        |-> (rdata_out[31:16] == 16'h0000))
        else $error("frame 2 read wider than 16 bits");
    byte_align_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (req_in && !busy_out && addr_in[`FRAME_LSB +: `FRAME_W] == `FRAME_BYTE_SEL
         && width_in == 2'h1 && addr_in[1:0] == 2'h2)
        |-> ##2 (ready_out && err_out))
        else $error("misaligned bridged word taken");
    upper_half_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (ready_out && is_byte && w16 && !wr_r && !err_out && byte_lane == 2'h2)
        |-> (rdata_out[15:0] == sel_rd[31:16]))
        else $error("bridged upper half not at base plus two");
    bridge_full_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (do_wr && is_byte && w32)
        |-> (b_lanes == 4'hf))
        else $error("bridged 32-bit write split");
    bridge_whole_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (ready_out && is_byte && w32 && !wr_r && !err_out)
        |-> (rdata_out == fb_rd))
        else $error("bridged 32-bit read not whole register");
    done_timing_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (req_in && !busy_out)
        |=> busy_out ##1 ready_out ##1 !busy_out)
        else $error("answer not two cycles after request");
    answer_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        ready_out
        |=> (!ready_out && rdata_out == $past(rdata_out) && err_out == $past(err_out)))
        else $error("answer not held after ready");
    refuse_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (ready_out && err_out)
        |-> (rdata_out == 32'h00000000))
        else $error("refused access returned data");
    can_word_only_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (ready_out && can_ctrl && !w32)
        |-> err_out)
        else $error("narrow can control access answered");
    frame2_half_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (req_in && !busy_out && addr_in[`FRAME_LSB +: `FRAME_W] == `FRAME2_SEL
         && width_in == 2'h0)
        |-> ##2 (ready_out && !err_out))
        else $error("16-bit frame 2 access refused");
    byte_any_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (req_in && !busy_out && addr_in[`FRAME_LSB +: `FRAME_W] == `FRAME_BYTE_SEL
         && width_in == 2'h2)
        |-> ##2 (ready_out && !err_out))
        else $error("bridged byte access refused");
    word_no_byte_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (req_in && !busy_out && addr_in[`FRAME_LSB +: `FRAME_W] != `FRAME_BYTE_SEL
         && width_in == 2'h2)
        |-> ##2 (ready_out && err_out))
        else $error("byte access taken outside the bridge");

    byte_rd_c: cover property (@(posedge clk_in) disable iff (rst_in)
        ready_out && is_byte && w8 && !wr_r);
    can_32_c: cover property (@(posedge clk_in) disable iff (rst_in)
        ready_out && can_ctrl && w32 && !err_out);
    f2_refuse_c: cover property (@(posedge clk_in) disable iff (rst_in)
        ready_out && is_f2 && err_out);
    can_16_c: cover property (@(posedge clk_in) disable iff (rst_in)
        ready_out && can_ctrl && w16 && err_out);
    upper_half_c: cover property (@(posedge clk_in) disable iff (rst_in)
        ready_out && is_byte && w16 && byte_lane == 2'h2 && !err_out);
endmodule // peripheral_frame_access_bridge
`default_nettype wire

// File: bus_master_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "frame_bridge_defs.svh"
// cpu side: one request at a time, held until ready; idle wr, addr and wdata lines carry inverted values
module bus_master_model (
    input wire logic clk_in,
    input wire logic ready_in,
    input wire logic [31:0] rdata_in,
    input wire logic err_in,
    input wire logic busy_in,
    output logic req_out,
    output logic wr_out,
    output logic [1:0] width_out,
    output logic [`ADDR_W-1:0] addr_out,
    output logic [31:0] wdata_out
);
    initial begin
        req_out = 1'b0;
        wr_out = 1'b0;
        width_out = 2'h0;
        addr_out = '0;
        wdata_out = 32'h0;
    end
    // the caller picks the width; a narrow access to can control is made only on purpose
    task automatic access(input logic wr, input logic [1:0] wd, input logic [`ADDR_W-1:0] a,
                          input logic [31:0] d, output logic [31:0] q, output logic e, output logic ok,
                          output logic [7:0] bz);
        ok = 1'b0;
        q = 32'h0;
        e = 1'b0;
        bz = 8'h00;
        @(posedge clk_in);
        req_out <= 1'b1;
        wr_out <= wr;
        width_out <= wd;
        addr_out <= a;
        wdata_out <= d;
        // request stands until the rising edge that samples ready high; answer taken there
        for (int n = 0; n < 8 && !ok; n++) begin
            @(posedge clk_in);
            bz[n] = busy_in;
            if (ready_in === 1'b1) begin
                ok = 1'b1;
                q = rdata_in;
                e = err_in;
            end
        end
        req_out <= 1'b0;
        wr_out <= ~wr;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask
endmodule // bus_master_model
`default_nettype wire

// File: peripheral_frame_access_bridge_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "frame_bridge_defs.svh"
module peripheral_frame_access_bridge_tb;
    localparam logic [1:0] w16 = frame_bridge_pkg::width_16;
    localparam logic [1:0] w32 = frame_bridge_pkg::width_32;
    localparam logic [1:0] w8 = frame_bridge_pkg::width_8;
    logic clk_in;
    logic rst_in;
    logic req, wr, ready, err, busy;
    logic [1:0] width;
    logic [`ADDR_W-1:0] addr;
    logic [31:0] wdata, rdata;
    int bad_count = 0;
    int tests_run = 0;
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    peripheral_frame_access_bridge dut_u (.clk_in(clk_in), .rst_in(rst_in), .req_in(req), .wr_in(wr),
        .width_in(width), .addr_in(addr), .wdata_in(wdata), .ready_out(ready), .rdata_out(rdata),
        .err_out(err), .busy_out(busy));
    bus_master_model master_u (.clk_in(clk_in), .ready_in(ready), .rdata_in(rdata), .err_in(err),
        .busy_in(busy), .req_out(req), .wr_out(wr), .width_out(width), .addr_out(addr), .wdata_out(wdata));
    function automatic logic [`ADDR_W-1:0] fa(input logic [1:0] f, input logic [11:0] o);
        return {8'h00, f, o};
    endfunction
    task automatic finish_test;
        $display("mismatches %0d, checks %0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [1:0] wd, input logic [`ADDR_W-1:0] a,
                       input logic [31:0] d, input logic [31:0] eq, input logic ee);
        logic [31:0] q;
        logic e, ok;
        logic [7:0] bz;
        master_u.access(w, wd, a, d, q, e, ok, bz);
        if (!ok) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
            finish_test();
        end else begin
            check_word(q, eq);
            check_bit(e, ee);
            // busy low at the taking edge, high at the next two; ready at the third edge
            check_word({24'h000000, bz}, 32'h0000_0006);
            // half a cycle later ready has dropped and the answer is still held
            @(negedge clk_in);
            check_bit(ready, 1'b0);
            check_word(rdata, eq);
            check_bit(err, ee);
        end
    endtask
    // writes and refusals both answer with zero data
    task automatic wr_acc(input logic [1:0] wd, input logic [`ADDR_W-1:0] a, input logic [31:0] d, input logic ee);
        acc(1'b1, wd, a, d, 32'h0, ee);
    endtask
    task automatic rd_acc(input logic [1:0] wd, input logic [`ADDR_W-1:0] a, input logic [31:0] eq, input logic ee);
        acc(1'b0, wd, a, 32'h0, eq, ee);
    endtask
    task automatic frame0_widths;
        wr_acc(w32, fa(2'h0, 12'h010), 32'h1234_5678, 1'b0);
        rd_acc(w32, fa(2'h0, 12'h011), 32'h1234_5678, 1'b0);
        rd_acc(w16, fa(2'h0, 12'h010), 32'h0000_5678, 1'b0);
        wr_acc(w16, fa(2'h0, 12'h011), 32'h0000_abcd, 1'b0);
        rd_acc(w32, fa(2'h0, 12'h010), 32'habcd_5678, 1'b0);
        rd_acc(w8, fa(2'h0, 12'h010), 32'h0, 1'b1);
        rd_acc(2'h3, fa(2'h0, 12'h010), 32'h0, 1'b1);
    endtask
    task automatic frame1_can;
        wr_acc(w32, fa(2'h1, 12'h100), 32'h0102_0304, 1'b0);
        wr_acc(w16, fa(2'h1, 12'h100), 32'h0000_aa55, 1'b0);
        rd_acc(w32, fa(2'h1, 12'h100), 32'h0102_aa55, 1'b0);
        wr_acc(w16, fa(2'h1, 12'h040), 32'h0000_5a5a, 1'b0);
        rd_acc(w16, fa(2'h1, 12'h040), 32'h0000_5a5a, 1'b0);
        wr_acc(w32, fa(2'h1, 12'h03e), 32'h0000_0001, 1'b0);
        wr_acc(w16, fa(2'h1, 12'h03f), 32'h0000_ffff, 1'b1);
        rd_acc(w16, fa(2'h1, 12'h03e), 32'h0, 1'b1);
        rd_acc(w32, fa(2'h1, 12'h03e), 32'h0000_0001, 1'b0);
        // field change by whole-word read, modify, whole-word write
        wr_acc(w32, fa(2'h1, 12'h000), 32'h0000_0010, 1'b0);
        rd_acc(w32, fa(2'h1, 12'h000), 32'h0000_0010, 1'b0);
        wr_acc(w32, fa(2'h1, 12'h000), 32'h0004_0010, 1'b0);
        rd_acc(w32, fa(2'h1, 12'h000), 32'h0004_0010, 1'b0);
    endtask
    task automatic frame2_narrow;
        wr_acc(w16, fa(2'h2, 12'h020), 32'hffff_beef, 1'b0);
        rd_acc(w16, fa(2'h2, 12'h020), 32'h0000_beef, 1'b0);
        wr_acc(w32, fa(2'h2, 12'h020), 32'h1111_2222, 1'b1);
        rd_acc(w32, fa(2'h2, 12'h020), 32'h0, 1'b1);
        rd_acc(w16, fa(2'h2, 12'h020), 32'h0000_beef, 1'b0);
    endtask
    task automatic byte_bridge;
        wr_acc(w32, fa(2'h3, 12'h008), 32'h0083_0000, 1'b0);
        wr_acc(w32, fa(2'h3, 12'h00c), 32'h7777_6666, 1'b0);
        rd_acc(w16, fa(2'h3, 12'h00a), 32'h0000_0083, 1'b0);
        wr_acc(w16, fa(2'h3, 12'h00a), 32'h0000_0487, 1'b0);
        rd_acc(w32, fa(2'h3, 12'h008), 32'h0487_0000, 1'b0);
        rd_acc(w8, fa(2'h3, 12'h00b), 32'h0000_0004, 1'b0);
        wr_acc(w8, fa(2'h3, 12'h009), 32'h0000_0055, 1'b0);
        rd_acc(w32, fa(2'h3, 12'h008), 32'h0487_5500, 1'b0);
        rd_acc(w16, fa(2'h3, 12'h00c), 32'h0000_6666, 1'b0);
        rd_acc(w32, fa(2'h3, 12'h00a), 32'h0, 1'b1);
        rd_acc(w16, fa(2'h3, 12'h009), 32'h0, 1'b1);
    endtask
    initial begin
        rst_in = 1'b1;
        repeat (12) @(posedge clk_in);
        @(negedge clk_in);
        check_bit(ready, 1'b0);
        check_bit(busy, 1'b0);
        check_bit(err, 1'b0);
        check_word(rdata, 32'h0);
        @(posedge clk_in);
        rst_in <= 1'b0;
        frame0_widths();
        frame1_can();
        frame2_narrow();
        byte_bridge();
        finish_test();
    end
endmodule // peripheral_frame_access_bridge_tb
`default_nettype wire
